// file: core/boot_mode_register_interface.sv
// Behaviour
// - program revision reads two bytes, major.minor, trivial
// - fault_source reads causes behind status error flag
// - invalid write register address sets fault bit 0
// - read of invalid register sets fault bit 1
// - unsupported measure_config write sets fault bit 2
// - sensor resistance overrange sets fault bit 3
// - heater current out of range sets bit 4
// - heater voltage fault sets fault bit 5
// - fault bits 6 and 7 reserved, zero
// - exact restart key in one write restarts
// - answer at 0x5A or 0x5B per select
// - boot mode read-only identity, revision and status
// - exact erase key in one write starts erase
// - erase done bit cleared only by reset, launch
// - nine byte chunks programmed in received order
// - image_check write starts full image check
// - check done bit cleared only by reset, launch
// - launch is pointer-only write of image_launch
// - launch runs program only when image valid
// - loader revision two bytes, same layout as program
`timescale 1ns/1ps
`default_nettype none

module boot_mode_register_interface
	import boot_regs_pkg::*;
#(
	parameter logic [7:0]  SILICON_ID  = 8'h5C,   // Arbitrary identity value
	parameter logic [7:0]  SILICON_REV = 8'h30,   // Arbitrary revision value
	parameter logic [15:0] LOADER_REV  = 16'h1000 // Arbitrary loader revision
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        address_select_pin,
	input  wire logic [15:0] program_revision,
	input  wire logic        image_valid,
	input  wire logic        erase_done,
	input  wire logic        check_done,
	input  wire fault_evt_t  fault_evt,
	output logic             erase_start,
	output logic             check_start,
	output logic             launch,
	output logic             soft_restart,
	output logic [71:0]      chunk_data,
	output logic             chunk_valid
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [1:0]  scl_sync_r;    // Two flops on the bus clock
	logic [1:0]  sda_sync_r;    // Two flops on the bus data
	logic [1:0]  asel_sync_r;   // Two flops on the address select
	logic        scl_prev_r;    // Last synchronised clock level
	logic        sda_prev_r;    // Last synchronised data level
	logic        scl_rise;      // Bus clock rising edge seen
	logic        scl_fall;      // Bus clock falling edge seen
	logic        bus_start;     // Start or repeated start
	logic        bus_stop;      // Stop condition
	logic        local_rst;     // Pin reset or keyed restart

	// Keyed restart resets everything here but the synchronisers and sda_out, like a power-on
	assign local_rst = !nrst || soft_restart;

	// Synchronisers; stage one only feeds stage two
	always_ff @(posedge clk) begin
		scl_sync_r  <= {scl_sync_r[0], scl_in};
		sda_sync_r  <= {sda_sync_r[0], sda_in};
		asel_sync_r <= {asel_sync_r[0], address_select_pin};
	end

	// Previous levels for edge finding
	always_ff @(posedge clk) begin
		if (local_rst) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= scl_sync_r[1];
			sda_prev_r <= sda_sync_r[1];
		end
	end

	assign scl_rise  = scl_sync_r[1] && !scl_prev_r;
	assign scl_fall  = !scl_sync_r[1] && scl_prev_r;
	// Data moving while the clock stays high frames a transfer
	assign bus_start = scl_sync_r[1] && scl_prev_r && sda_prev_r && !sda_sync_r[1];
	assign bus_stop  = scl_sync_r[1] && scl_prev_r && !sda_prev_r && sda_sync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// Register map helpers

	// Registers that may be read
	function automatic logic readable(input logic [7:0] a);
		readable = (a == ADDR_DEVICE_STATUS) || (a == ADDR_SILICON_IDENTITY) ||
			(a == ADDR_SILICON_REVISION) || (a == ADDR_LOADER_REVISION) ||
			(a == ADDR_PROGRAM_REVISION) || (a == ADDR_FAULT_SOURCE);
	endfunction : readable

	// Registers that may take data after the pointer byte
	function automatic logic writable(input logic [7:0] a);
		writable = (a == ADDR_IMAGE_ERASE_KEY) || (a == ADDR_IMAGE_CHUNK) ||
			(a == ADDR_IMAGE_CHECK) || (a == ADDR_SOFT_RESTART_KEY);
	endfunction : writable

	// Key byte n, first byte in the top lane
	function automatic logic [7:0] key_byte(input logic [31:0] k, input logic [3:0] n);
		key_byte = k[8'(31 - 8 * 32'(n)) -: 8];
	endfunction : key_byte

	////////////////////////////////////////////////////////////////////////////
	// Status and fault state

	logic [7:0]  fault_r;       // Sticky fault causes
	logic        erase_done_r;  // Erase completed
	logic        check_done_r;  // Image check completed
	logic [7:0]  status;        // Assembled status byte
	logic        wr_fault;      // Bad write target this cycle
	logic        rd_fault;      // Bad read target this cycle

	// Fault bits are sticky until reset; reserved bits stay zero
	always_ff @(posedge clk) begin
		if (local_rst) begin
			fault_r <= FAULT_RESET;
		end else begin
			if (wr_fault)
				fault_r[FAULT_BAD_WRITE_TARGET] <= 1'b1;
			if (rd_fault)
				fault_r[FAULT_BAD_READ_TARGET] <= 1'b1;
			if (fault_evt.bad_measure_setting)
				fault_r[FAULT_BAD_MEASURE_SETTING] <= 1'b1;
			if (fault_evt.sense_overrange)
				fault_r[FAULT_SENSE_OVERRANGE] <= 1'b1;
			if (fault_evt.heater_current_fault)
				fault_r[FAULT_HEATER_CURRENT] <= 1'b1;
			if (fault_evt.heater_voltage_fault)
				fault_r[FAULT_HEATER_VOLTAGE] <= 1'b1;
		end
	end

	// Completion flags: zero at start, set on done, cleared by launch only
	always_ff @(posedge clk) begin
		if (local_rst) begin
			erase_done_r <= 1'b0;
			check_done_r <= 1'b0;
		end else begin
			// A completion landing with a launch still wins, no lost done
			if (erase_done || launch)
				erase_done_r <= erase_done;
			if (check_done || launch)
				check_done_r <= check_done;
		end
	end

	// Status byte; program mode bit reads zero while in boot mode
	always_comb begin
		status                        = BYTE_ZERO;
		status[STAT_ERROR_BIT]        = |(fault_r & FAULT_USED_MASK);
		status[STAT_IMAGE_VALID_BIT]  = image_valid;
		status[STAT_CHECK_DONE_BIT]   = check_done_r;
		status[STAT_ERASE_DONE_BIT]   = erase_done_r;
		status[STAT_PROGRAM_MODE_BIT] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data selection

	logic [7:0]  ptr_r;         // Selected register
	logic [3:0]  rd_idx_r;      // Byte index within a read
	logic [7:0]  rd_byte;       // Byte to send next

	// Beyond a register's size the host gets zero bytes
	always_comb begin
		rd_byte = BYTE_ZERO;
		unique case (ptr_r)
			ADDR_DEVICE_STATUS:
				if (rd_idx_r == 4'h0) rd_byte = status;
			ADDR_SILICON_IDENTITY:
				if (rd_idx_r == 4'h0) rd_byte = SILICON_ID;
			ADDR_SILICON_REVISION:
				if (rd_idx_r == 4'h0) rd_byte = SILICON_REV;
			ADDR_LOADER_REVISION:
				if (rd_idx_r == 4'h0) rd_byte = LOADER_REV[15:8];
				else if (rd_idx_r == 4'h1) rd_byte = LOADER_REV[7:0];
			ADDR_PROGRAM_REVISION:
				if (rd_idx_r == 4'h0) rd_byte = program_revision[15:8];
				else if (rd_idx_r == 4'h1) rd_byte = program_revision[7:0];
			ADDR_FAULT_SOURCE:
				if (rd_idx_r == 4'h0) rd_byte = fault_r & FAULT_USED_MASK;
			default:
				rd_byte = BYTE_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Link state machine

	link_state_t state_r;       // Link state
	logic [3:0]  bit_cnt_r;     // Bits moved in this byte
	logic [7:0]  shift_r;       // Receive shifter
	logic [7:0]  tx_r;          // Transmit byte
	logic        read_r;        // Transfer direction is read
	logic        wr_open_r;     // A write transfer awaits its end
	logic [3:0]  wr_cnt_r;      // Bytes written incl. pointer
	logic        key_ok_r;      // Key bytes matched so far
	logic        byte_in;       // A written byte completes now
	logic [7:0]  byte_val;      // Value of that byte
	logic        addr_match;    // Address byte names us

	assign byte_val   = shift_r;
	assign byte_in    = (state_r == LS_WR) && scl_fall && (bit_cnt_r == 4'h8);
	assign addr_match = shift_r[7:1] == {TARGET_ADDR_BASE[6:1], asel_sync_r[1]};
	assign rd_fault   = (state_r == LS_ADDR_ACK) && scl_fall && read_r && !readable(ptr_r);
	assign wr_fault   = byte_in && ((wr_cnt_r == 4'h0) ?
		!(readable(byte_val) || writable(byte_val) || byte_val == ADDR_IMAGE_LAUNCH) :
		!writable(ptr_r));

	// Bit and byte sequencing; data lane only ever pulls low
	always_ff @(posedge clk) begin
		if (local_rst) begin
			state_r   <= LS_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= BYTE_ZERO;
			tx_r      <= BYTE_ZERO;
			read_r    <= 1'b0;
			sda_oe_n  <= 1'b1;
			rd_idx_r  <= 4'h0;
		end else if (bus_start) begin
			state_r   <= LS_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_n  <= 1'b1;
		end else if (bus_stop) begin
			state_r   <= LS_IDLE;
			sda_oe_n  <= 1'b1;
		end else begin
			unique case (state_r)
				LS_IDLE: sda_oe_n <= 1'b1;
				LS_ADDR, LS_WR: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_sync_r[1]};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						bit_cnt_r <= 4'h0;
						// Other addresses are left alone, no acknowledge
						if (state_r == LS_WR || addr_match) begin
							sda_oe_n <= 1'b0;
							state_r  <= (state_r == LS_WR) ? LS_WR_ACK : LS_ADDR_ACK;
							if (state_r == LS_ADDR) begin
								read_r   <= shift_r[0];
								rd_idx_r <= 4'h0;
							end
						end else begin
							state_r <= LS_IDLE;
						end
					end
				end
				LS_ADDR_ACK: begin
					if (scl_fall) begin
						if (read_r) begin
							tx_r     <= rd_byte;
							sda_oe_n <= rd_byte[7];
							state_r  <= LS_RD;
						end else begin
							sda_oe_n <= 1'b1;
							state_r  <= LS_WR;
						end
					end
				end
				LS_WR_ACK: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						state_r  <= LS_WR;
					end
				end
				LS_RD: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_n  <= 1'b1;
							bit_cnt_r <= 4'h0;
							rd_idx_r  <= rd_idx_r + 4'h1;
							state_r   <= LS_RD_ACK;
						end else begin
							sda_oe_n <= tx_r[3'(7 - bit_cnt_r)];
						end
					end
				end
				LS_RD_ACK: begin
					// Host acknowledge asks for another byte
					if (scl_rise && sda_sync_r[1]) begin
						state_r <= LS_IDLE;
					end else if (scl_fall) begin
						tx_r     <= rd_byte;
						sda_oe_n <= rd_byte[7];
						state_r  <= LS_RD;
					end
				end
				default: state_r <= LS_IDLE;
			endcase
		end
	end

	// Open-drain lane: the output level is always low
	always_ff @(posedge clk) begin
		sda_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Write collection

	// Pointer, byte count, key check and chunk assembly
	always_ff @(posedge clk) begin
		if (local_rst) begin
			ptr_r      <= BYTE_ZERO;
			wr_cnt_r   <= 4'h0;
			key_ok_r   <= 1'b0;
			wr_open_r  <= 1'b0;
			chunk_data <= 72'h0;
		end else if (bus_start || bus_stop) begin
			wr_open_r <= 1'b0;
		end else if (state_r == LS_ADDR_ACK && scl_fall && !read_r) begin
			wr_open_r <= 1'b1;
			wr_cnt_r  <= 4'h0;
			key_ok_r  <= 1'b1;
		end else if (byte_in) begin
			if (wr_cnt_r != 4'hF)
				wr_cnt_r <= wr_cnt_r + 4'h1;
			if (wr_cnt_r == 4'h0) begin
				ptr_r <= byte_val;
			end else begin
				// Bytes past the first go to the selected register
				if (ptr_r == ADDR_IMAGE_ERASE_KEY && wr_cnt_r <= KEY_BYTES)
					key_ok_r <= key_ok_r &&
						byte_val == key_byte(ERASE_KEY, wr_cnt_r - 4'h1);
				if (ptr_r == ADDR_SOFT_RESTART_KEY && wr_cnt_r <= KEY_BYTES)
					key_ok_r <= key_ok_r &&
						byte_val == key_byte(RESTART_KEY, wr_cnt_r - 4'h1);
				if (ptr_r == ADDR_IMAGE_CHUNK)
					chunk_data <= {chunk_data[63:0], byte_val};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command issue at the end of a write

	logic        wr_end;        // A write transfer closes now

	// A repeated start closes the write just like a stop
	assign wr_end = wr_open_r && (bus_start || bus_stop);

	// One-cycle command pulses; wrong byte counts do nothing
	always_ff @(posedge clk) begin
		if (local_rst) begin
			erase_start  <= 1'b0;
			check_start  <= 1'b0;
			launch       <= 1'b0;
			soft_restart <= 1'b0;
			chunk_valid  <= 1'b0;
		end else begin
			erase_start  <= wr_end && ptr_r == ADDR_IMAGE_ERASE_KEY &&
				wr_cnt_r == KEY_BYTES + 4'h1 && key_ok_r;
			soft_restart <= wr_end && ptr_r == ADDR_SOFT_RESTART_KEY &&
				wr_cnt_r == KEY_BYTES + 4'h1 && key_ok_r;
			chunk_valid  <= wr_end && ptr_r == ADDR_IMAGE_CHUNK &&
				wr_cnt_r == CHUNK_BYTES + 4'h1;
			check_start  <= wr_end && ptr_r == ADDR_IMAGE_CHECK &&
				wr_cnt_r <= 4'h2 && wr_cnt_r != 4'h0;
			launch       <= wr_end && ptr_r == ADDR_IMAGE_LAUNCH &&
				wr_cnt_r == 4'h1 && image_valid;
		end
	end

endmodule : boot_mode_register_interface

`default_nettype wire

// file: core/boot_regs_pkg.sv
package boot_regs_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_DEVICE_STATUS     = 8'h00;
	localparam logic [7:0] ADDR_SILICON_IDENTITY  = 8'h20;
	localparam logic [7:0] ADDR_SILICON_REVISION  = 8'h21;
	localparam logic [7:0] ADDR_LOADER_REVISION   = 8'h23;
	localparam logic [7:0] ADDR_PROGRAM_REVISION  = 8'h24;
	localparam logic [7:0] ADDR_FAULT_SOURCE      = 8'hE0;
	localparam logic [7:0] ADDR_IMAGE_ERASE_KEY   = 8'hF1;
	localparam logic [7:0] ADDR_IMAGE_CHUNK       = 8'hF2;
	localparam logic [7:0] ADDR_IMAGE_CHECK       = 8'hF3;
	localparam logic [7:0] ADDR_IMAGE_LAUNCH      = 8'hF4;
	localparam logic [7:0] ADDR_SOFT_RESTART_KEY  = 8'hFF;

	// Target address, low bit from the select pin
	localparam logic [6:0] TARGET_ADDR_BASE       = 7'h5A;

	// Command keys, first byte in the top lane
	localparam logic [31:0] ERASE_KEY             = 32'hE7A7_E609;
	localparam logic [31:0] RESTART_KEY           = 32'h11E5_728A;
	localparam logic [3:0]  KEY_BYTES             = 4'h4;
	localparam logic [3:0]  CHUNK_BYTES           = 4'h9;

	// Status bit positions
	localparam int STAT_ERROR_BIT                 = 0;
	localparam int STAT_IMAGE_VALID_BIT           = 4;
	localparam int STAT_CHECK_DONE_BIT            = 5;
	localparam int STAT_ERASE_DONE_BIT            = 6;
	localparam int STAT_PROGRAM_MODE_BIT          = 7;

	// Fault source bit positions
	localparam int FAULT_BAD_WRITE_TARGET         = 0;
	localparam int FAULT_BAD_READ_TARGET          = 1;
	localparam int FAULT_BAD_MEASURE_SETTING      = 2;
	localparam int FAULT_SENSE_OVERRANGE          = 3;
	localparam int FAULT_HEATER_CURRENT           = 4;
	localparam int FAULT_HEATER_VOLTAGE           = 5;
	localparam logic [7:0] FAULT_USED_MASK        = 8'h3F;

	// Reset values
	localparam logic [7:0] FAULT_RESET            = 8'h00;
	localparam logic [7:0] BYTE_ZERO              = 8'h00;

	// Fault events raised by the sensor side logic
	typedef struct packed {
		logic heater_voltage_fault;
		logic heater_current_fault;
		logic sense_overrange;
		logic bad_measure_setting;
	} fault_evt_t;

	// Link state
	typedef enum logic [2:0] {
		LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WR, LS_WR_ACK, LS_RD, LS_RD_ACK
	} link_state_t;

endpackage : boot_regs_pkg

// file: dv/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus host: drives the bus clock and releases data to the pull-up
module i2c_host_model (
	input  wire logic clk,      // System clock, paces the bus
	input  wire logic sda_line, // Resolved data wire
	output logic      scl,      // Bus clock, still and high between frames
	output logic      sda_rel   // 1 = released, 0 = pulled low
);
	localparam int QUARTER = 10; // Quarter of a 160 ns bus period

	// Idle bus
	initial begin
		scl     = 1'b1;
		sda_rel = 1'b1;
	end

	task automatic q_wait();
		repeat (QUARTER) @(posedge clk);
	endtask : q_wait

	// Start and stop move data while the clock is high
	task automatic start();
		sda_rel <= 1'b1;
		q_wait();
		scl <= 1'b1;
		q_wait();
		sda_rel <= 1'b0;
		q_wait();
		scl <= 1'b0;
		q_wait();
	endtask : start

	task automatic stop();
		sda_rel <= 1'b0;
		q_wait();
		scl <= 1'b1;
		q_wait();
		sda_rel <= 1'b1;
		q_wait();
	endtask : stop

	// Sampled mid high phase, well after the device's lag
	task automatic bit_io(input logic b, output logic r);
		sda_rel <= b;
		q_wait();
		scl <= 1'b1;
		q_wait();
		r = sda_line;
		q_wait();
		scl <= 1'b0;
		q_wait();
	endtask : bit_io

	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : tx

	// Host NACKs the last byte, so never reads past the size
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : rx

	// Keys and commands go whole in one write, pointer first
	task automatic wr(input logic [6:0] a, input logic [7:0] b[$], output logic ok);
		logic ack;
		start();
		tx({a, 1'b0}, ok);
		foreach (b[i]) begin
			if (ok) begin
				tx(b[i], ack);
				ok = ok & ack;
			end
		end
		stop();
	endtask : wr

	// Pointer write, repeated start, then n bytes
	task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
		output logic [7:0] d[$]);
		logic       ack;
		logic [7:0] b;
		d = {};
		start();
		tx({a, 1'b0}, ack);
		tx(p, ack);
		start();
		tx({a, 1'b1}, ack);
		for (int k = 0; k < n; k++) begin
			rx(k == n - 1, b);
			d.push_back(b);
		end
		stop();
	endtask : rd
endmodule : i2c_host_model

`default_nettype wire

// file: dv/boot_mode_register_interface_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the boot register block
module boot_mode_register_interface_asserts (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic scl_in,
	input  wire logic sda_oe_n,
	input  wire logic image_valid,
	input  wire logic erase_start,
	input  wire logic check_start,
	input  wire logic launch,
	input  wire logic soft_restart,
	input  wire logic chunk_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////
	// Command pulses
	AST_ERASE_PULSE: assert property (erase_start |=> !erase_start)
		else $error("erase start wider than one cycle");
	// Commands fire at stop or restart, both seen with the clock high
	AST_ERASE_AT_END: assert property (erase_start |-> scl_in && $past(scl_in))
		else $error("erase start outside a frame end");
	AST_CHUNK_PULSE: assert property (chunk_valid |=> !chunk_valid [*8])
		else $error("chunk valid repeated too soon");
	AST_CHECK_PULSE: assert property (check_start |=> !check_start)
		else $error("check start wider than one cycle");
	AST_RESTART_PULSE: assert property (soft_restart |=> !soft_restart [*4])
		else $error("restart pulse repeated");
	AST_LAUNCH_GATED: assert property (launch |-> image_valid && $past(image_valid))
		else $error("launch without a valid image");
	AST_ONE_COMMAND: assert property ($onehot0({erase_start, check_start, launch,
		soft_restart, chunk_valid}))
		else $error("two commands from one write");

	////////////////////////////////////////////////////////////////
	// Data pin timing: hazard is a false start or stop
	AST_PIN_CHANGE_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data pin changed with clock high");
	// Ack plus a zero byte is the longest low stretch
	AST_DRIVE_BOUNDED: assert property ($fell(sda_oe_n) |-> ##[1:400] sda_oe_n)
		else $error("data pin held low too long");

	// Main scenarios
	COV_ERASE: cover property (erase_start);
	COV_CHUNK: cover property (chunk_valid);
	COV_LAUNCH: cover property (launch);
endmodule : boot_mode_register_interface_asserts

bind boot_mode_register_interface boot_mode_register_interface_asserts
	boot_mode_register_interface_asserts_i (.clk(clk), .nrst(nrst), .scl_in(scl_in),
	.sda_oe_n(sda_oe_n), .image_valid(image_valid), .erase_start(erase_start),
	.check_start(check_start), .launch(launch), .soft_restart(soft_restart),
	.chunk_valid(chunk_valid));

`default_nettype wire

// file: dv/boot_mode_register_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none

module boot_mode_register_interface_tb;
	import boot_regs_pkg::*;
	localparam logic [7:0]  SID  = 8'h6B;    // Arbitrary identity value
	localparam logic [7:0]  SREV = 8'h27;    // Arbitrary revision value
	localparam logic [15:0] LREV = 16'h1203; // Arbitrary loader revision

	logic        clk, nrst, sel, ival, edone, cdone;
	logic        sda_out, sda_oe_n, er, ck, ln, rs, cv;
	logic [15:0] prev;
	logic [71:0] cdata, chunk_seen;
	fault_evt_t  fevt;
	logic        scl, sda_rel;
	wire logic   sda_line;
	logic [6:0]  dev;
	int          n_mismatch, checks, n_er, n_ck, n_ln, n_rs, n_ch;

	// Pull-up wire shared by host and device
	assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;

	boot_mode_register_interface #(.SILICON_ID(SID), .SILICON_REV(SREV),
		.LOADER_REV(LREV)) boot_mode_register_interface_i (.clk(clk), .nrst(nrst),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.address_select_pin(sel), .program_revision(prev), .image_valid(ival),
		.erase_done(edone), .check_done(cdone), .fault_evt(fevt), .erase_start(er),
		.check_start(ck), .launch(ln), .soft_restart(rs), .chunk_data(cdata),
		.chunk_valid(cv));

	i2c_host_model i2c_host_model_i (.clk(clk), .sda_line(sda_line), .scl(scl),
		.sda_rel(sda_rel));

	////////////////////////////////////////////////////////////////
	// Pulse tallies
	always @(posedge clk) begin
		n_er <= n_er + int'(er);
		n_ck <= n_ck + int'(ck);
		n_ln <= n_ln + int'(ln);
		n_rs <= n_rs + int'(rs);
		n_ch <= n_ch + int'(cv);
		if (cv) chunk_seen <= cdata;
	end

	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Read n bytes, first byte lands high
	task automatic rd_chk(input logic [7:0] p, input int n, input logic [15:0] exp);
		logic [7:0]  d[$];
		logic [15:0] v;
		i2c_host_model_i.rd(dev, p, n, d);
		v = '0;
		foreach (d[i]) v = {v[7:0], d[i]};
		check(72'(v), 72'(exp));
	endtask : rd_chk

	task automatic t_idents();
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0000);
		rd_chk(ADDR_SILICON_IDENTITY, 1, 16'(SID));
		rd_chk(ADDR_SILICON_REVISION, 1, 16'(SREV));
		rd_chk(ADDR_LOADER_REVISION, 2, LREV);
		rd_chk(ADDR_PROGRAM_REVISION, 2, 16'h2107);
	endtask : t_idents

	// Other address ignored once the select pin moves
	task automatic t_select();
		logic ok;
		sel <= 1'b1;
		repeat (5) @(posedge clk);
		i2c_host_model_i.wr(7'h5A, '{ADDR_DEVICE_STATUS}, ok);
		check(72'(ok), 72'h0);
		i2c_host_model_i.wr(7'h5B, '{ADDR_DEVICE_STATUS}, ok);
		check(72'(ok), 72'h1);
		sel <= 1'b0;
		repeat (5) @(posedge clk);
	endtask : t_select

	task automatic t_erase();
		logic ok;
		int   e0;
		e0 = n_er;
		i2c_host_model_i.wr(dev, '{8'hF1, 8'hE7, 8'hA7, 8'hE6, 8'h08}, ok);
		check(72'(n_er - e0), 72'h0);
		i2c_host_model_i.wr(dev, '{8'hF1, 8'hE7, 8'hA7, 8'hE6, 8'h09}, ok);
		check(72'(n_er - e0), 72'h1);
		edone <= 1'b1;
		@(posedge clk);
		edone <= 1'b0;
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0040);
	endtask : t_erase

	// Short chunk dropped, full chunk kept in order
	task automatic t_chunk();
		logic ok;
		int   c0;
		c0 = n_ch;
		i2c_host_model_i.wr(dev, '{8'hF2, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
			8'h07, 8'h08}, ok);
		check(72'(n_ch - c0), 72'h0);
		i2c_host_model_i.wr(dev, '{8'hF2, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6,
			8'h07, 8'h18, 8'h29}, ok);
		check(72'(n_ch - c0), 72'h1);
		check(chunk_seen, 72'hA1_B2C3_D4E5_F607_1829);
	endtask : t_chunk

	task automatic t_check_launch();
		logic ok;
		int   k0, l0;
		k0 = n_ck;
		l0 = n_ln;
		i2c_host_model_i.wr(dev, '{ADDR_IMAGE_CHECK}, ok);
		check(72'(n_ck - k0), 72'h1);
		i2c_host_model_i.wr(dev, '{ADDR_IMAGE_CHECK, 8'h00, 8'h00}, ok);
		check(72'(n_ck - k0), 72'h1);
		cdone <= 1'b1;
		@(posedge clk);
		cdone <= 1'b0;
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0060);
		i2c_host_model_i.wr(dev, '{ADDR_IMAGE_LAUNCH}, ok);
		check(72'(n_ln - l0), 72'h0);
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0060);
		ival <= 1'b1;
		// Data after the launch pointer is a bad write target
		i2c_host_model_i.wr(dev, '{ADDR_IMAGE_LAUNCH, 8'h00}, ok);
		check(72'(n_ln - l0), 72'h0);
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0071);
		i2c_host_model_i.wr(dev, '{ADDR_IMAGE_LAUNCH}, ok);
		check(72'(n_ln - l0), 72'h1);
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0011);
	endtask : t_check_launch

	task automatic t_faults();
		logic ok;
		i2c_host_model_i.wr(dev, '{8'h30, 8'h00}, ok);
		rd_chk(ADDR_FAULT_SOURCE, 1, 16'h0001);
		rd_chk(8'h30, 1, 16'h0000);
		rd_chk(ADDR_FAULT_SOURCE, 1, 16'h0003);
		// One event per cycle, lowest field first
		for (int i = 0; i < 4; i++) begin
			fevt <= fault_evt_t'(4'h1 << i);
			@(posedge clk);
		end
		fevt <= '0;
		rd_chk(ADDR_FAULT_SOURCE, 1, 16'h003F);
		rd_chk(ADDR_DEVICE_STATUS, 1, 16'h0011);
	endtask : t_faults

	task automatic t_restart();
		logic ok;
		int   r0;
		r0 = n_rs;
		i2c_host_model_i.wr(dev, '{8'hFF, 8'h11, 8'hE5, 8'h72, 8'h8B}, ok);
		check(72'(n_rs - r0), 72'h0);
		i2c_host_model_i.wr(dev, '{8'hFF, 8'h11, 8'hE5, 8'h72, 8'h8A}, ok);
		check(72'(n_rs - r0), 72'h1);
		rd_chk(ADDR_FAULT_SOURCE, 1, 16'h0000);
		// Faults are clear again, so a bad target must show alone
		i2c_host_model_i.wr(dev, '{8'h30, 8'h00}, ok);
		rd_chk(ADDR_FAULT_SOURCE, 1, 16'h0001);
	endtask : t_restart

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog, about one and a half times the expected run
	initial begin
		#320000;
		n_mismatch++;
		end_of_test();
	end

	// Main sequence
	initial begin
		nrst = 1'b0;
		sel = 1'b0;
		ival = 1'b0;
		edone = 1'b0;
		cdone = 1'b0;
		prev = 16'h2107;
		fevt = '0;
		dev = TARGET_ADDR_BASE;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_idents();
		t_select();
		t_erase();
		t_chunk();
		t_check_launch();
		t_faults();
		t_restart();
		end_of_test();
	end
endmodule : boot_mode_register_interface_tb

`default_nettype wire
